// *** rtl/rtc_alarm_pkg.sv ***
package rtc_alarm_pkg;
    // Clock figures
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned HALF_SEC_MS     = 500;
    localparam int unsigned HALF_SEC_CYCLES = CLK_HZ / 1000 * HALF_SEC_MS;

    // Register offsets (byte addresses)
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_STATUS  = 4'h4;
    localparam logic [3:0] OFS_MASK    = 4'h8;
    localparam logic [3:0] OFS_LOCK    = 4'hC;

    // Control register fields
    localparam int unsigned BIT_ALARM_EN   = 31;
    localparam int unsigned BIT_WRAP_EN    = 30;
    localparam int unsigned POS_INTERVAL   = 24;
    localparam int unsigned POS_REPEAT     = 16;
    localparam int unsigned BIT_MODULE_EN  = 15;
    localparam int unsigned BIT_WRITE_LOCK = 11;
    localparam int unsigned BIT_OUT_EN     = 7;
    localparam int unsigned POS_OUT_SEL    = 4;
    localparam logic [31:0] CONTROL_WMASK  = 32'hCFFF_88F0;
    localparam logic [31:0] CONTROL_RESET  = 32'h0000_0000;

    // Status bits
    localparam int unsigned ST_ALARM  = 0;
    localparam int unsigned ST_SECOND = 1;
    localparam int unsigned ST_WIDTH  = 2;

    // Unlock keys, written in sequence to the lock register
    localparam logic [31:0] UNLOCK_KEY_A = 32'hAA99_6655;
    localparam logic [31:0] UNLOCK_KEY_B = 32'h5566_99AA;

    // Interval codes
    typedef enum logic [3:0] {
        IV_HALF_SEC = 4'h0,
        IV_SECOND   = 4'h1,
        IV_TEN_SEC  = 4'h2,
        IV_MINUTE   = 4'h3,
        IV_TEN_MIN  = 4'h4,
        IV_HOUR     = 4'h5,
        IV_DAY      = 4'h6,
        IV_WEEK     = 4'h7,
        IV_MONTH    = 4'h8,
        IV_YEAR     = 4'h9
    } interval_t;

    typedef enum logic [1:0] {
        LK_LOCKED = 2'b00,
        LK_KEY_A  = 2'b01,
        LK_OPEN   = 2'b11
    } lock_state_t;
endpackage

// *** rtl/alarm_tick_divider.sv ***
`timescale 1ns/1ps
// Half-second tick enable from the system clock; count cleared and tick low while disabled
module alarm_tick_divider (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic srst_i,
    // Control
    input  wire logic run_i,
    // Tick
    output logic      tick_o
);
    logic [24:0] count_r;

    always_ff @(posedge clk_sys_i) begin
        if (srst_i || !run_i) begin
            count_r <= 25'h0000000;
            tick_o  <= 1'b0;
        end else if (count_r == 25'(rtc_alarm_pkg::HALF_SEC_CYCLES - 1)) begin
            count_r <= 25'h0000000;
            tick_o  <= 1'b1;
        end else begin
            count_r <= count_r + 25'h0000001;
            tick_o  <= 1'b0;
        end
    end
endmodule // alarm_tick_divider

// *** rtl/rtc_alarm_control.sv ***
// The implementer's own choices: the register addresses and the strobed register port.
`timescale 1ns/1ps
// Summary of operation
// - Alarm events only while alarm enable set
// - Wrap enable lets repeat count wrap 00 to FF
// - Interval code selects alarm period
// - Repeat count N gives N further alarms
// - Each alarm event decrements repeat count, except at zero without wrap
// - Module enable gates all counting
// - Unimplemented control bits read zero
module rtc_alarm_control (
    // Clock and reset
    input  wire logic        clk_sys_i,
    input  wire logic        srst_i,
    // Register port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    // Current time and alarm time from the calendar counters, same clock
    input  wire logic [4:0]  cur_sec_tens_units_i,
    input  wire logic [5:0]  cur_sec_i,
    input  wire logic [5:0]  cur_min_i,
    input  wire logic [4:0]  cur_hour_i,
    input  wire logic [2:0]  cur_wday_i,
    input  wire logic [4:0]  cur_mday_i,
    input  wire logic [3:0]  cur_month_i,
    input  wire logic        cur_half_i,
    input  wire logic [5:0]  alm_sec_i,
    input  wire logic [5:0]  alm_min_i,
    input  wire logic [4:0]  alm_hour_i,
    input  wire logic [2:0]  alm_wday_i,
    input  wire logic [4:0]  alm_mday_i,
    input  wire logic [3:0]  alm_month_i,
    input  wire logic        time_update_i,
    // Output pin
    output logic             clk_unit_pin_o,
    output logic             clk_unit_pin_oe_o,
    // Interrupt and status
    output logic             irq_o,
    output logic             module_en_o,
    output logic             alarm_event_o
);
    localparam int unsigned ST_WIDTH_L = rtc_alarm_pkg::ST_WIDTH;
    logic [31:0] control_r;
    logic [ST_WIDTH_L-1:0] status_r;
    logic [ST_WIDTH_L-1:0] mask_r;
    logic        alarm_en;
    logic        wrap_en;
    logic [3:0]  interval;
    logic [7:0]  repeat_cnt;
    logic        out_en;
    logic [2:0]  out_sel;
    logic        half_tick;
    logic        match;
    logic        match_d_r;
    logic        alarm_done_r;
    logic        alarm_evt;
    logic        alarm_pulse_r;
    logic        sec_phase_r;
    rtc_alarm_pkg::lock_state_t lock_r;
    logic        wr_ctl;
    logic        wr_lock;

    assign alarm_en   = control_r[rtc_alarm_pkg::BIT_ALARM_EN];
    assign wrap_en    = control_r[rtc_alarm_pkg::BIT_WRAP_EN];
    assign interval   = control_r[rtc_alarm_pkg::POS_INTERVAL +: 4];
    assign repeat_cnt = control_r[rtc_alarm_pkg::POS_REPEAT +: 8];
    assign out_en     = control_r[rtc_alarm_pkg::BIT_OUT_EN];
    assign out_sel    = control_r[rtc_alarm_pkg::POS_OUT_SEL +: 3];
    assign module_en_o = control_r[rtc_alarm_pkg::BIT_MODULE_EN];
    assign wr_ctl  = wr_i && (addr_i == rtc_alarm_pkg::OFS_CONTROL);
    assign wr_lock = wr_i && (addr_i == rtc_alarm_pkg::OFS_LOCK);

    alarm_tick_divider u_div (
        .clk_sys_i (clk_sys_i),
        .srst_i    (srst_i),
        .run_i     (module_en_o),
        .tick_o    (half_tick)
    );

    // Field compare for the selected interval; coarser codes match as many fields or more
    function automatic logic field_match(input logic [3:0] code, input logic [5:0] cs, input logic [5:0] as_,
                                         input logic [5:0] cm, input logic [5:0] am, input logic [4:0] ch,
                                         input logic [4:0] ah, input logic [2:0] cw, input logic [2:0] aw,
                                         input logic [4:0] cd, input logic [4:0] ad, input logic [3:0] cmo,
                                         input logic [3:0] amo);
        logic ok;
        ok = 1'b1;
        unique case (code)
            rtc_alarm_pkg::IV_HALF_SEC: ok = 1'b1;
            rtc_alarm_pkg::IV_SECOND:   ok = 1'b1;
            rtc_alarm_pkg::IV_TEN_SEC:  ok = (cs % 6'd10) == (as_ % 6'd10);
            rtc_alarm_pkg::IV_MINUTE:   ok = cs == as_;
            rtc_alarm_pkg::IV_TEN_MIN:  ok = cs == as_ && (cm % 6'd10) == (am % 6'd10);
            rtc_alarm_pkg::IV_HOUR:     ok = cs == as_ && cm == am;
            rtc_alarm_pkg::IV_DAY:      ok = cs == as_ && cm == am && ch == ah;
            rtc_alarm_pkg::IV_WEEK:     ok = cs == as_ && cm == am && ch == ah && cw == aw;
            rtc_alarm_pkg::IV_MONTH:    ok = cs == as_ && cm == am && ch == ah && cd == ad;
            rtc_alarm_pkg::IV_YEAR:     ok = cs == as_ && cm == am && ch == ah && cd == ad && cmo == amo;
            default:                    ok = 1'b0; // Reserved codes never match
        endcase
        return ok;
    endfunction

    // Half-second code fires on every tick; second code on every other tick
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sec_phase_r <= 1'b0;
        end else if (half_tick) begin
            sec_phase_r <= ~sec_phase_r;
        end
    end

    always_comb begin
        match = field_match(interval, cur_sec_i, alm_sec_i, cur_min_i, alm_min_i, cur_hour_i, alm_hour_i,
                            cur_wday_i, alm_wday_i, cur_mday_i, alm_mday_i, cur_month_i, alm_month_i);
        if (interval == rtc_alarm_pkg::IV_HALF_SEC) begin
            match = half_tick;
        end else if (interval == rtc_alarm_pkg::IV_SECOND) begin
            match = half_tick && sec_phase_r;
        end else begin
            match = match && time_update_i && !cur_half_i;
        end
    end

    // Match edge, qualified by enables and the last-shot flag
    assign alarm_evt = module_en_o && alarm_en && !alarm_done_r && match && !match_d_r;

    // Tick codes skip the edge detect: the tick is already a one-cycle pulse
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            match_d_r <= 1'b0;
        end else if (interval > rtc_alarm_pkg::IV_SECOND) begin
            match_d_r <= match;
        end else begin
            match_d_r <= 1'b0;
        end
    end

    // Once the count sits at zero without wrap, one more alarm ends the series
    // The last shot wins over a same-cycle re-arm, as the count decrement does
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            alarm_done_r <= 1'b0;
        end else if (alarm_evt && repeat_cnt == 8'h00 && !wrap_en) begin
            alarm_done_r <= 1'b1;
        end else if (wr_ctl && wdata_i[rtc_alarm_pkg::BIT_ALARM_EN]) begin
            alarm_done_r <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            alarm_pulse_r <= 1'b0;
        end else begin
            alarm_pulse_r <= alarm_evt;
        end
    end
    assign alarm_event_o = alarm_pulse_r;

    // Unlock sequence: key A then key B opens one write that may clear the lock
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            lock_r <= rtc_alarm_pkg::LK_LOCKED;
        end else if (wr_lock) begin
            if (wdata_i == rtc_alarm_pkg::UNLOCK_KEY_A) begin
                lock_r <= rtc_alarm_pkg::LK_KEY_A;
            end else if (wdata_i == rtc_alarm_pkg::UNLOCK_KEY_B && lock_r == rtc_alarm_pkg::LK_KEY_A) begin
                lock_r <= rtc_alarm_pkg::LK_OPEN;
            end else begin
                lock_r <= rtc_alarm_pkg::LK_LOCKED;
            end
        end else if (wr_ctl) begin
            // The open state serves one control write only
            lock_r <= rtc_alarm_pkg::LK_LOCKED;
        end
    end

    // Control register; repeat decrement wins over a same-cycle write of the count
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            control_r <= rtc_alarm_pkg::CONTROL_RESET;
        end else begin
            if (wr_ctl) begin
                control_r <= wdata_i & rtc_alarm_pkg::CONTROL_WMASK;
                // Setting the lock is always allowed; clearing it needs the open state
                if (control_r[rtc_alarm_pkg::BIT_WRITE_LOCK] && lock_r != rtc_alarm_pkg::LK_OPEN) begin
                    control_r[rtc_alarm_pkg::BIT_WRITE_LOCK] <= 1'b1;
                end
            end
            if (alarm_evt) begin
                if (repeat_cnt != 8'h00 || wrap_en) begin
                    control_r[rtc_alarm_pkg::POS_REPEAT +: 8] <= repeat_cnt - 8'h01;
                end
            end
        end
    end

    // Sticky status, write one to clear, set wins
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            status_r <= '0;
        end else begin
            status_r <= (status_r & ~((wr_i && addr_i == rtc_alarm_pkg::OFS_STATUS) ?
                         wdata_i[ST_WIDTH_L-1:0] : {ST_WIDTH_L{1'b0}}))
                        | {half_tick && sec_phase_r, alarm_evt};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            mask_r <= '0;
        end else if (wr_i && addr_i == rtc_alarm_pkg::OFS_MASK) begin
            mask_r <= wdata_i[ST_WIDTH_L-1:0];
        end
    end
    // Level output; it stays high until software clears the flag or the mask bit
    assign irq_o = |(status_r & mask_r);

    // Reads have no side effects, so polling the status never loses a flag
    // Read data stand for one cycle after the strobe
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (rd_i) begin
            unique case (addr_i)
                rtc_alarm_pkg::OFS_CONTROL: rdata_o <= control_r & rtc_alarm_pkg::CONTROL_WMASK;
                rtc_alarm_pkg::OFS_STATUS:  rdata_o <= {{(32-ST_WIDTH_L){1'b0}}, status_r};
                rtc_alarm_pkg::OFS_MASK:    rdata_o <= {{(32-ST_WIDTH_L){1'b0}}, mask_r};
                rtc_alarm_pkg::OFS_LOCK:    rdata_o <= {30'h0000_0000, lock_r};
                default:                    rdata_o <= 32'h0000_0000;
            endcase
        end else begin
            rdata_o <= 32'h0000_0000;
        end
    end

    // Pin output: 0 alarm pulse, 1 second toggle, 2 half-second tick, others low
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            clk_unit_pin_o    <= 1'b0;
            clk_unit_pin_oe_o <= 1'b0;
        end else begin
            clk_unit_pin_oe_o <= out_en;
            unique case (out_sel)
                3'h0:    clk_unit_pin_o <= alarm_evt;
                3'h1:    clk_unit_pin_o <= sec_phase_r;
                3'h2:    clk_unit_pin_o <= half_tick;
                default: clk_unit_pin_o <= 1'b0;
            endcase
        end
    end

    a_alarm_gated: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        alarm_pulse_r |-> $past(alarm_en) && $past(module_en_o))
        else $error("alarm event without enables");
    a_repeat_hold: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        alarm_evt && !wr_ctl && repeat_cnt == 8'h00 && !wrap_en |=> repeat_cnt == 8'h00)
        else $error("repeat count left zero without wrap");
    a_repeat_wrap: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        alarm_evt && repeat_cnt == 8'h00 && wrap_en |=> repeat_cnt == 8'hFF)
        else $error("repeat count did not wrap");
    a_repeat_dec: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        alarm_evt && repeat_cnt != 8'h00 |=> repeat_cnt == $past(repeat_cnt) - 8'h01)
        else $error("repeat count not decremented");
    a_last_shot: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        alarm_evt && repeat_cnt == 8'h00 && !wrap_en && !wr_ctl |=> !alarm_evt [*2])
        else $error("alarm after last shot");
    a_idle_no_tick: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        !module_en_o |=> !half_tick)
        else $error("tick while disabled");
    a_lock_kept: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        wr_ctl && control_r[rtc_alarm_pkg::BIT_WRITE_LOCK] && lock_r != rtc_alarm_pkg::LK_OPEN
        |=> control_r[rtc_alarm_pkg::BIT_WRITE_LOCK])
        else $error("lock cleared without unlock");
    a_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        $past(rd_i) && $past(addr_i) == rtc_alarm_pkg::OFS_CONTROL |-> (rdata_o & ~rtc_alarm_pkg::CONTROL_WMASK) == 32'h0)
        else $error("reserved control bits read nonzero");
    a_flag_set: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        alarm_evt |=> status_r[rtc_alarm_pkg::ST_ALARM])
        else $error("alarm flag not set");
    a_pin_enable: assert property (@(posedge clk_sys_i) disable iff (srst_i)
        out_en |=> clk_unit_pin_oe_o ##0 1'b1)
        else $error("pin not driven when enabled");
endmodule // rtc_alarm_control

// *** verif/rtc_alarm_control_tb.sv ***
`timescale 1ns/1ps
module rtc_alarm_control_tb;
    logic        clk_sys_i     = 1'b0;
    logic        srst_i        = 1'b1;
    logic [3:0]  addr_i        = 4'h0;
    logic [31:0] wdata_i       = 32'h0;
    logic        wr_i          = 1'b0;
    logic        rd_i          = 1'b0;
    logic [31:0] rdata_o;
    logic [5:0]  cur_sec_i     = 6'h05;
    logic        time_update_i = 1'b0;
    logic [5:0]  cur_min_i     = 6'h0A;
    logic [4:0]  cur_hour_i    = 5'h03;
    logic [2:0]  cur_wday_i    = 3'h2;
    logic [4:0]  cur_mday_i    = 5'h0C;
    logic [3:0]  cur_month_i   = 4'h4;
    logic        cur_half_i    = 1'b0;
    logic [5:0]  alm_sec_i     = 6'h05;
    logic [5:0]  alm_min_i     = 6'h0A;
    logic [4:0]  alm_hour_i    = 5'h03;
    logic [2:0]  alm_wday_i    = 3'h2;
    logic [4:0]  alm_mday_i    = 5'h0C;
    logic [3:0]  alm_month_i   = 4'h4;
    int          pin_hits      = 0;
    logic        clk_unit_pin_o;
    logic        clk_unit_pin_oe_o;
    logic        irq_o;
    logic        module_en_o;
    logic        alarm_event_o;
    int          fails         = 0;
    int          n_checks      = 0;
    localparam logic [31:0] AEN = 32'h8000_0000;
    localparam logic [31:0] WRP = 32'h4000_0000;
    localparam logic [31:0] MOD = 32'h0000_8000;

    always #12.5 clk_sys_i = ~clk_sys_i;

    // Alarm fields start equal to the current ones; hit toggles seconds, skew moves one field
    rtc_alarm_control i_dut (
        .clk_sys_i(clk_sys_i), .srst_i(srst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .cur_sec_tens_units_i(5'h00), .cur_sec_i(cur_sec_i),
        .cur_min_i(cur_min_i), .cur_hour_i(cur_hour_i), .cur_wday_i(cur_wday_i), .cur_mday_i(cur_mday_i),
        .cur_month_i(cur_month_i), .cur_half_i(cur_half_i), .alm_sec_i(alm_sec_i), .alm_min_i(alm_min_i),
        .alm_hour_i(alm_hour_i), .alm_wday_i(alm_wday_i), .alm_mday_i(alm_mday_i), .alm_month_i(alm_month_i),
        .time_update_i(time_update_i), .clk_unit_pin_o(clk_unit_pin_o),
        .clk_unit_pin_oe_o(clk_unit_pin_oe_o), .irq_o(irq_o), .module_en_o(module_en_o),
        .alarm_event_o(alarm_event_o)
    );

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // A gap cycle before each strobe keeps every signal to one assignment per time step
    task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        #1;
    endtask

    task automatic bus_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1;
        d = rdata_o;
    endtask

    // Mismatch then match on an update, then count event cycles over a bounded window
    task automatic hit(output int n);
        n = 0;
        pin_hits = 0;
        @(posedge clk_sys_i);
        cur_sec_i     <= 6'h06;
        time_update_i <= 1'b1;
        @(posedge clk_sys_i);
        time_update_i <= 1'b0;
        @(posedge clk_sys_i);
        cur_sec_i     <= 6'h05;
        time_update_i <= 1'b1;
        @(posedge clk_sys_i);
        time_update_i <= 1'b0;
        repeat (6) begin
            #1;
            if (alarm_event_o === 1'b1) n++;
            if (clk_unit_pin_o === 1'b1) pin_hits++;
            @(posedge clk_sys_i);
        end
    endtask

    // Moves one time field: one that code c compares, or with relevant low one that it ignores
    task automatic skew(input int c, input bit relevant);
        @(posedge clk_sys_i);
        case (relevant ? c : c + 8)
            2:       alm_sec_i   <= 6'h04;
            3, 10:   alm_sec_i   <= 6'h0F;
            4:       alm_min_i   <= 6'h0B;
            5, 12:   alm_min_i   <= 6'h14;
            6:       alm_hour_i  <= 5'h04;
            7:       alm_wday_i  <= 3'h3;
            8:       alm_mday_i  <= 5'h0D;
            9:       alm_month_i <= 4'h5;
            11:      cur_min_i   <= 6'h0B;
            13:      cur_hour_i  <= 5'h04;
            14, 17:  cur_wday_i  <= 3'h3;
            15:      cur_mday_i  <= 5'h0D;
            16:      cur_month_i <= 4'h5;
            default: ;
        endcase
    endtask

    task automatic align();
        @(posedge clk_sys_i);
        alm_sec_i   <= 6'h05;
        alm_min_i   <= 6'h0A;
        alm_hour_i  <= 5'h03;
        alm_wday_i  <= 3'h2;
        alm_mday_i  <= 5'h0C;
        alm_month_i <= 4'h4;
        cur_min_i   <= 6'h0A;
        cur_hour_i  <= 5'h03;
        cur_wday_i  <= 3'h2;
        cur_mday_i  <= 5'h0C;
        cur_month_i <= 4'h4;
    endtask

    task automatic t_reset_and_bits();
        logic [31:0] d;
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("control reset", d, 32'h0);
        check("outputs reset", {irq_o, module_en_o, clk_unit_pin_oe_o}, 32'h0);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, 32'hC9FF_FFFF);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("control ones", d, 32'hC9FF_88F0);
        check("module enable on", module_en_o, 1'b1);
        bus_wr(4'h1, 32'hFFFF_FFFF);
        bus_rd(4'h1, d);
        check("unmapped read", d, 32'h0);
        $display("test reset_and_bits done");
    endtask

    task automatic t_write_lock();
        logic [31:0] d;
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, 32'h0);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("lock held", d, 32'h0000_0800);
        check("module enable off", module_en_o, 1'b0);
        bus_wr(rtc_alarm_pkg::OFS_LOCK, rtc_alarm_pkg::UNLOCK_KEY_B);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, 32'h0);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("lock wrong key", d, 32'h0000_0800);
        bus_wr(rtc_alarm_pkg::OFS_LOCK, rtc_alarm_pkg::UNLOCK_KEY_A);
        bus_wr(rtc_alarm_pkg::OFS_LOCK, rtc_alarm_pkg::UNLOCK_KEY_B);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, 32'h0);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("lock cleared", d, 32'h0);
        $display("test write_lock done");
    endtask

    task automatic t_codes();
        logic [31:0] d;
        int          n;
        for (int c = 2; c <= 9; c++) begin
            bus_wr(rtc_alarm_pkg::OFS_STATUS, 32'h3);
            bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | MOD | (32'(c) << 24));
            hit(n);
            check("event per code", 32'(n), 32'h1);
            bus_rd(rtc_alarm_pkg::OFS_STATUS, d);
            check("alarm flag", d & 32'h1, 32'h1);
            hit(n);
            check("no repeat at zero", 32'(n), 32'h0);
            bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | MOD | (32'(c) << 24));
            skew(c, 1'b1);
            hit(n);
            check("compared field", 32'(n), 32'h0);
            align();
            skew(c, 1'b0);
            hit(n);
            check("ignored field", 32'(n), 32'h1);
            align();
        end
        for (int c = 0; c <= 1; c++) begin
            bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | MOD | (32'(c) << 24));
            hit(n);
            check("tick code ignores match", 32'(n), 32'h0);
        end
        bus_wr(rtc_alarm_pkg::OFS_STATUS, 32'h3);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, MOD | 32'h0300_0000);
        hit(n);
        check("alarm disabled", 32'(n), 32'h0);
        bus_rd(rtc_alarm_pkg::OFS_STATUS, d);
        check("no flag disabled", d & 32'h1, 32'h0);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | MOD | 32'h0300_0000);
        @(posedge clk_sys_i);
        cur_half_i <= 1'b1;
        hit(n);
        check("second half ignored", 32'(n), 32'h0);
        @(posedge clk_sys_i);
        cur_half_i <= 1'b0;
        $display("test codes done");
    endtask

    task automatic t_repeat();
        logic [31:0] d;
        int          n;
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | MOD | 32'h0301_0000);
        hit(n);
        check("first of two", 32'(n), 32'h1);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("count down", d & 32'h00FF_0000, 32'h0);
        hit(n);
        check("second of two", 32'(n), 32'h1);
        hit(n);
        check("stops after", 32'(n), 32'h0);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("count holds", d & 32'h00FF_0000, 32'h0);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | WRP | MOD | 32'h0300_0000);
        hit(n);
        check("wrap event", 32'(n), 32'h1);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("count wraps", d & 32'h00FF_0000, 32'h00FF_0000);
        hit(n);
        check("chime goes on", 32'(n), 32'h1);
        bus_rd(rtc_alarm_pkg::OFS_CONTROL, d);
        check("count after wrap", d & 32'h00FF_0000, 32'h00FE_0000);
        $display("test repeat done");
    endtask

    task automatic t_irq_and_pin();
        logic [31:0] d;
        int          n;
        check("irq masked", irq_o, 1'b0);
        bus_wr(rtc_alarm_pkg::OFS_MASK, 32'h1);
        check("irq raised", irq_o, 1'b1);
        bus_wr(rtc_alarm_pkg::OFS_STATUS, 32'h1);
        bus_rd(rtc_alarm_pkg::OFS_STATUS, d);
        check("flag cleared", d & 32'h1, 32'h0);
        check("irq dropped", irq_o, 1'b0);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, 32'h0000_00B0);
        @(posedge clk_sys_i);
        #1;
        check("pin driven", clk_unit_pin_oe_o, 1'b1);
        check("pin spare source", clk_unit_pin_o, 1'b0);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, 32'h0000_0030);
        @(posedge clk_sys_i);
        #1;
        check("pin released", clk_unit_pin_oe_o, 1'b0);
        bus_wr(rtc_alarm_pkg::OFS_CONTROL, AEN | MOD | 32'h0300_0080);
        hit(n);
        check("pin alarm pulse", 32'(pin_hits), 32'h1);
        check("irq from alarm", irq_o, 1'b1);
        $display("test irq_and_pin done");
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_reset_and_bits();
        t_write_lock();
        t_codes();
        t_repeat();
        t_irq_and_pin();
        give_verdict();
    end
endmodule // rtc_alarm_control_tb
